// *** common/gpp_defines.vh ***
// Constants for the pin and pulse-width port controller
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH

`define GPP_CLK_PERIOD_NS    5
`define GPP_PWM_PERIOD_NS    10000000
`define GPP_PWM_STEPS        100
`define GPP_SAMPLE_PERIOD_NS 31250000

`define GPP_NUM_GPIO 5
`define GPP_NUM_LED  8
`define GPP_NUM_LINE 13
`define GPP_LAST_GPIO 8'h04
`define GPP_LAST_LINE 8'h0c
`define GPP_LVL_HIGH  7'h64
`define GPP_LVL_MAXB  8'h64
`define GPP_CFG_MAXB  8'h0f

`define GPP_CMD_SET   8'h22
`define GPP_RESP_FLAG 8'h40
`define GPP_ERR_FLAG  8'h80

`define GPP_OFF_CMD    8'h00
`define GPP_OFF_GO     8'h04
`define GPP_OFF_RESP   8'h08
`define GPP_OFF_QUERY  8'h0c
`define GPP_OFF_QRES   8'h10
`define GPP_OFF_ISTAT  8'h14
`define GPP_OFF_IMASK  8'h18
`define GPP_OFF_STORE  8'h1c

`define GPP_F_IDX   7:0
`define GPP_F_LVL   15:8
`define GPP_F_CFG   23:16
`define GPP_B_HASCF 24
`define GPP_B_STORE 0
`define GPP_B_LOAD  1

`define GPP_CFG_FSEL 3
`define GPP_DM_UP_PD   3'h0
`define GPP_DM_PUSH    3'h1
`define GPP_DM_HIZ     3'h2
`define GPP_DM_PU_DN   3'h3
`define GPP_DM_UP_FLT  3'h4
`define GPP_DM_PUSH2   3'h5
`define GPP_DM_RSVD    3'h6
`define GPP_DM_FLT_DN  3'h7

`define GPP_CFG_DEF_SENSE 4'h3
`define GPP_CFG_DEF_IDLE  4'h2
`define GPP_IDX_SENSE     1

`define GPP_IRQ_W     3
`define GPP_IRQ_DONE  0
`define GPP_IRQ_ERR   1
`define GPP_IRQ_EDGE  2

`define GPP_RESP_OKAY   2'h0
`define GPP_RESP_SLVERR 2'h2

`endif

// *** hw/gpp_pwm.v ***
// Shared 100-step pulse-width generator for all output lines
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.vh"
module gpp_pwm #(
  parameter integer STEP_CYCLES = 20000
) (
  input  wire                          clk,
  input  wire                          rst,
  input  wire [7*`GPP_NUM_LINE-1:0]    level,
  output reg  [`GPP_NUM_LINE-1:0]      pwm_q
);
  reg  [31:0] pre_q;
  reg  [6:0]  step_q;
  wire        step_end = (pre_q == STEP_CYCLES - 1);
  genvar      i;

  always @(posedge clk) begin
    if (rst) begin
      pre_q  <= 32'h0;
      step_q <= 7'h0;
    end else if (step_end) begin
      pre_q  <= 32'h0;
      step_q <= (step_q == `GPP_PWM_STEPS - 1) ? 7'h0 : step_q + 7'h1;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  generate
    for (i = 0; i < `GPP_NUM_LINE; i = i + 1) begin : g_line
      wire [6:0] lvl = level[7*i +: 7];
      always @(posedge clk) begin
        if (rst)
          pwm_q[i] <= 1'b0;
        else
          pwm_q[i] <= (lvl == `GPP_LVL_HIGH) | (step_q < lvl);
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** hw/gpp_sampler.v ***
// Periodic input sampler with rising and falling edge flags
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.vh"
module gpp_sampler #(
  parameter integer SAMPLE_CYCLES = 6250000
) (
  input  wire                     clk,
  input  wire                     rst,
  input  wire [`GPP_NUM_GPIO-1:0] pin_i,
  input  wire [`GPP_NUM_GPIO-1:0] clr,
  output reg  [`GPP_NUM_GPIO-1:0] state_q,
  output reg  [`GPP_NUM_GPIO-1:0] rise_q,
  output reg  [`GPP_NUM_GPIO-1:0] fall_q,
  output reg                      edge_q
);
  reg  [31:0] cnt_q;
  reg         primed_q;
  wire        tick = (cnt_q == SAMPLE_CYCLES - 1);
  wire [`GPP_NUM_GPIO-1:0] up = pin_i & ~state_q & {`GPP_NUM_GPIO{tick & primed_q}};
  wire [`GPP_NUM_GPIO-1:0] dn = ~pin_i & state_q & {`GPP_NUM_GPIO{tick & primed_q}};

  always @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 32'h0;
      primed_q <= 1'b0;
      state_q  <= {`GPP_NUM_GPIO{1'b0}};
      rise_q   <= {`GPP_NUM_GPIO{1'b0}};
      fall_q   <= {`GPP_NUM_GPIO{1'b0}};
      edge_q   <= 1'b0;
    end else begin
      cnt_q  <= tick ? 32'h0 : cnt_q + 32'h1;
      edge_q <= |(up | dn);
      if (tick) begin
        state_q  <= pin_i;
        primed_q <= 1'b1;
      end
      // Set wins over a query clear in the same cycle
      rise_q <= (rise_q & ~clr) | up;
      fall_q <= (fall_q & ~clr) | dn;
    end
  end
endmodule
`default_nettype wire

// *** hw/gpp_top.v ***
// Pin and pulse-width port controller with register access
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.vh"
// Overview of operation
// - Five bidirectional pins, each input or output, shared with default power roles.
// - Index 0-4 selects pins, 5-12 LED lines, 13-255 nothing.
// - Level 0 low, 1-99 duty percent at 100 Hz, 100 high, above invalid.
// - Two-byte set changes level only; three-byte also changes function and drive.
// - Configuration byte valid 0-15 except 6 and 14; upper bits reserved.
// - Reserved drive pattern rejects the request with an error answer.
// - Drive encodings give strong, resistive, floating high and low as listed.
// - Function bit clear gives default role; set gives user control.
// - LED lines ignore the configuration byte, act on level only.
// - Pins are sampled as inputs at 32 Hz continuously.
// - Rising and falling edges seen in samples are recorded until queried.
// - Pull-up mode reads one when open, zero when shorted low.
// - Default roles: pin 1 power sense, pin 2 power control, pin 3 reset.
// - Levels and pin configuration are saved on store and restored on load, not at power-up.
// - Query reports level and edge flags, then clears the flags.
module gpp_top #(
  parameter integer PWM_STEP_CYCLES =
    `GPP_PWM_PERIOD_NS / `GPP_CLK_PERIOD_NS / `GPP_PWM_STEPS,
  parameter integer SAMPLE_CYCLES = `GPP_SAMPLE_PERIOD_NS / `GPP_CLK_PERIOD_NS
) (
  input  wire                     clk,
  input  wire                     rst,
  input  wire [7:0]               s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [7:0]               s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  input  wire [`GPP_NUM_GPIO-1:0] gpio_i,
  output reg  [`GPP_NUM_GPIO-1:0] gpio_o,
  output reg  [`GPP_NUM_GPIO-1:0] gpio_oe,
  output reg  [`GPP_NUM_GPIO-1:0] gpio_pu_en,
  output reg  [`GPP_NUM_GPIO-1:0] gpio_pd_en,
  output reg  [`GPP_NUM_LED-1:0]  led_o,
  input  wire                     atx_pwr_act,
  input  wire                     atx_pwr_lvl,
  input  wire                     atx_rst_act,
  input  wire                     atx_rst_lvl,
  output wire                     atx_power_sense,
  output wire                     irq
);
  reg  [6:0]  level_q [0:`GPP_NUM_LINE-1];
  reg  [3:0]  cfg_q   [0:`GPP_NUM_GPIO-1];
  reg  [6:0]  boot_level_q [0:`GPP_NUM_LINE-1];
  reg  [3:0]  boot_cfg_q   [0:`GPP_NUM_GPIO-1];
  reg  [31:0] cmd_q;
  reg  [7:0]  resp_type_q;
  reg         resp_valid_q;
  reg  [31:0] qres_q;
  reg  [`GPP_IRQ_W-1:0] istat_q;
  reg  [`GPP_IRQ_W-1:0] imask_q;
  reg  [7:0]  awaddr_q;
  reg         aw_have_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_have_q;
  reg  [`GPP_NUM_GPIO-1:0] qclr;
  wire [7*`GPP_NUM_LINE-1:0] level_flat;
  wire [`GPP_NUM_LINE-1:0]   pwm;
  wire [`GPP_NUM_GPIO-1:0]   smp_state;
  wire [`GPP_NUM_GPIO-1:0]   smp_rise;
  wire [`GPP_NUM_GPIO-1:0]   smp_fall;
  wire                       smp_edge;
  wire [`GPP_NUM_GPIO-1:0]   def_act = {1'b0, atx_rst_act, atx_pwr_act, 2'b00};
  wire [`GPP_NUM_GPIO-1:0]   def_lvl = {1'b0, atx_rst_lvl, atx_pwr_lvl, 2'b00};
  integer k;
  genvar  i;

  // Bus write decode
  wire        wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wval = wdata_q & wmask;
  wire        wr_cmd   = wr_fire & (awaddr_q == `GPP_OFF_CMD);
  wire        wr_go    = wr_fire & (awaddr_q == `GPP_OFF_GO) & wval[0];
  wire        wr_query = wr_fire & (awaddr_q == `GPP_OFF_QUERY);
  wire        wr_istat = wr_fire & (awaddr_q == `GPP_OFF_ISTAT);
  wire        wr_imask = wr_fire & (awaddr_q == `GPP_OFF_IMASK);
  wire        wr_store = wr_fire & (awaddr_q == `GPP_OFF_STORE);
  wire        wr_map = (awaddr_q == `GPP_OFF_CMD) | (awaddr_q == `GPP_OFF_GO) |
                       (awaddr_q == `GPP_OFF_RESP) | (awaddr_q == `GPP_OFF_QUERY) |
                       (awaddr_q == `GPP_OFF_QRES) | (awaddr_q == `GPP_OFF_ISTAT) |
                       (awaddr_q == `GPP_OFF_IMASK) | (awaddr_q == `GPP_OFF_STORE);

  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready  = ~w_have_q;
  assign s_axi_arready = ~s_axi_rvalid;

  // Set request check
  wire [7:0] c_idx = cmd_q[`GPP_F_IDX];
  wire [7:0] c_lvl = cmd_q[`GPP_F_LVL];
  wire [7:0] c_cfg = cmd_q[`GPP_F_CFG];
  wire       c_has = cmd_q[`GPP_B_HASCF];
  wire       c_pin = (c_idx <= `GPP_LAST_GPIO);
  wire       bad_idx = (c_idx > `GPP_LAST_LINE);
  wire       bad_lvl = (c_lvl > `GPP_LVL_MAXB);
  wire       bad_cfg = c_has & c_pin & ((c_cfg > `GPP_CFG_MAXB) |
                       (c_cfg[2:0] == `GPP_DM_RSVD));
  wire       c_err = bad_idx | bad_lvl | bad_cfg;
  wire [3:0] c_slot = c_idx[3:0];
  wire [2:0] c_pslot = c_idx[2:0];

  // Query result assembly
  wire [7:0] q_idx = wval[`GPP_F_IDX];
  wire [3:0] q_slot = q_idx[3:0];
  wire [2:0] q_pslot = q_idx[2:0];
  wire       q_pin = (q_idx <= `GPP_LAST_GPIO);
  wire       q_ok = (q_idx <= `GPP_LAST_LINE);
  wire [7:0] q_state = q_pin ?
             {5'h0, smp_rise[q_pslot], smp_fall[q_pslot], smp_state[q_pslot]} : 8'h0;
  wire [7:0] q_lvl = q_ok ? {1'b0, level_q[q_slot]} : 8'h0;
  wire [7:0] q_cfg = q_pin ? {4'h0, cfg_q[q_pslot]} : 8'h0;

  always @* begin
    qclr = {`GPP_NUM_GPIO{1'b0}};
    if (wr_query && q_pin)
      qclr[q_pslot] = 1'b1;
  end

  function [3:0] cfg_default;
    input integer n;
    begin
      cfg_default = (n == `GPP_IDX_SENSE) ? `GPP_CFG_DEF_SENSE : `GPP_CFG_DEF_IDLE;
    end
  endfunction

  // Line state, boot image and command answer
  always @(posedge clk) begin
    if (rst) begin
      for (k = 0; k < `GPP_NUM_LINE; k = k + 1) begin
        level_q[k]      <= 7'h0;
        boot_level_q[k] <= 7'h0;
      end
      for (k = 0; k < `GPP_NUM_GPIO; k = k + 1) begin
        cfg_q[k]      <= cfg_default(k);
        boot_cfg_q[k] <= cfg_default(k);
      end
      cmd_q        <= 32'h0;
      resp_type_q  <= 8'h0;
      resp_valid_q <= 1'b0;
      qres_q       <= 32'h0;
    end else begin
      if (wr_cmd)
        cmd_q <= (cmd_q & ~wmask) | wval;
      if (wr_go) begin
        resp_valid_q <= 1'b1;
        if (c_err) begin
          resp_type_q <= `GPP_CMD_SET | `GPP_RESP_FLAG | `GPP_ERR_FLAG;
        end else begin
          resp_type_q      <= `GPP_CMD_SET | `GPP_RESP_FLAG;
          level_q[c_slot]  <= c_lvl[6:0];
          if (c_has && c_pin)
            cfg_q[c_pslot] <= c_cfg[3:0];
        end
      end
      if (wr_query)
        qres_q <= {q_cfg, q_lvl, q_state, q_idx};
      if (wr_store && wval[`GPP_B_STORE]) begin
        for (k = 0; k < `GPP_NUM_LINE; k = k + 1)
          boot_level_q[k] <= level_q[k];
        for (k = 0; k < `GPP_NUM_GPIO; k = k + 1)
          boot_cfg_q[k] <= cfg_q[k];
      end else if (wr_store && wval[`GPP_B_LOAD]) begin
        for (k = 0; k < `GPP_NUM_LINE; k = k + 1)
          level_q[k] <= boot_level_q[k];
        for (k = 0; k < `GPP_NUM_GPIO; k = k + 1)
          cfg_q[k] <= boot_cfg_q[k];
      end
    end
  end

  // Interrupt status, set wins over write-one-to-clear
  wire [`GPP_IRQ_W-1:0] ev;
  assign ev[`GPP_IRQ_DONE] = wr_go & ~c_err;
  assign ev[`GPP_IRQ_ERR]  = wr_go & c_err;
  assign ev[`GPP_IRQ_EDGE] = smp_edge;
  assign irq = |(istat_q & imask_q);

  always @(posedge clk) begin
    if (rst) begin
      istat_q <= {`GPP_IRQ_W{1'b0}};
      imask_q <= {`GPP_IRQ_W{1'b0}};
    end else begin
      istat_q <= (istat_q & ~(wr_istat ? wval[`GPP_IRQ_W-1:0] : {`GPP_IRQ_W{1'b0}})) | ev;
      if (wr_imask)
        imask_q <= wval[`GPP_IRQ_W-1:0];
    end
  end

  // Bus write channels
  always @(posedge clk) begin
    if (rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Bus read channel
  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  reg  [31:0] rd_d;
  reg         rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (raddr)
      `GPP_OFF_CMD:   rd_d = cmd_q;
      `GPP_OFF_GO:    rd_d = 32'h0;
      `GPP_OFF_RESP:  rd_d = {15'h0, resp_valid_q, 8'h0, resp_type_q};
      `GPP_OFF_QUERY: rd_d = 32'h0;
      `GPP_OFF_QRES:  rd_d = qres_q;
      `GPP_OFF_ISTAT: rd_d = {{(32-`GPP_IRQ_W){1'b0}}, istat_q};
      `GPP_OFF_IMASK: rd_d = {{(32-`GPP_IRQ_W){1'b0}}, imask_q};
      `GPP_OFF_STORE: rd_d = 32'h0;
      default: begin
        rd_d  = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `GPP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin drive per drive mode
  generate
    for (i = 0; i < `GPP_NUM_LINE; i = i + 1) begin : g_flat
      assign level_flat[7*i +: 7] = level_q[i];
    end
    for (i = 0; i < `GPP_NUM_GPIO; i = i + 1) begin : g_pin
      wire       dflt = ~cfg_q[i][`GPP_CFG_FSEL];
      wire [2:0] dm   = cfg_q[i][2:0];
      wire       v    = pwm[i];
      reg        o_d, oe_d, pu_d, pd_d;
      always @* begin
        o_d  = 1'b0;
        oe_d = 1'b0;
        pu_d = 1'b0;
        pd_d = 1'b0;
        if (dflt && def_act[i]) begin
          o_d  = def_lvl[i];
          oe_d = 1'b1;
        end else begin
          case (dm)
            `GPP_DM_UP_PD: begin
              o_d  = 1'b1;
              oe_d = v;
              pd_d = ~v;
            end
            `GPP_DM_PUSH, `GPP_DM_PUSH2: begin
              o_d  = v;
              oe_d = 1'b1;
            end
            `GPP_DM_PU_DN: begin
              o_d  = 1'b0;
              oe_d = ~v;
              pu_d = v;
            end
            `GPP_DM_UP_FLT: begin
              o_d  = 1'b1;
              oe_d = v;
            end
            `GPP_DM_FLT_DN: begin
              o_d  = 1'b0;
              oe_d = ~v;
            end
            default: begin
              o_d  = 1'b0;
              oe_d = 1'b0;
            end
          endcase
        end
      end
      always @(posedge clk) begin
        if (rst) begin
          gpio_o[i]     <= 1'b0;
          gpio_oe[i]    <= 1'b0;
          gpio_pu_en[i] <= 1'b0;
          gpio_pd_en[i] <= 1'b0;
        end else begin
          gpio_o[i]     <= o_d;
          gpio_oe[i]    <= oe_d;
          gpio_pu_en[i] <= pu_d;
          gpio_pd_en[i] <= pd_d;
        end
      end
    end
    for (i = 0; i < `GPP_NUM_LED; i = i + 1) begin : g_led
      always @(posedge clk) begin
        if (rst)
          led_o[i] <= 1'b0;
        else
          led_o[i] <= pwm[`GPP_NUM_GPIO + i];
      end
    end
  endgenerate

  assign atx_power_sense = smp_state[`GPP_IDX_SENSE];

  gpp_pwm #(
    .STEP_CYCLES (PWM_STEP_CYCLES)
  ) u_pwm (
    .clk   (clk),
    .rst   (rst),
    .level (level_flat),
    .pwm_q (pwm)
  );

  gpp_sampler #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_smp (
    .clk     (clk),
    .rst     (rst),
    .pin_i   (gpio_i),
    .clr     (qclr),
    .state_q (smp_state),
    .rise_q  (smp_rise),
    .fall_q  (smp_fall),
    .edge_q  (smp_edge)
  );
endmodule
`default_nettype wire

// *** testbench/gpp_top_chk.sv ***
// Bus handshake and pin drive assertions for the port controller
`timescale 1ns/100ps
`default_nettype none
module gpp_top_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [4:0]  gpio_oe,
  input wire logic [4:0]  gpio_pu_en,
  input wire logic [4:0]  gpio_pd_en,
  input wire logic [7:0]  led_o,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  aw_stall_a: assert property (aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channel taken twice");
  ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  drive_excl_a: assert property (((gpio_oe & gpio_pu_en) | (gpio_oe & gpio_pd_en)) == 5'h00)
    else $error("strong and resistive drive together");
  reset_idle_a: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && led_o == 8'h00 && !irq)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// *** testbench/gpp_pin_load.sv ***
// Pin load model: external switch, pull resistors and floating pins
`timescale 1ns/100ps
`default_nettype none
module gpp_pin_load (
  input  wire logic       clk,
  input  wire logic [4:0] gpio_o,
  input  wire logic [4:0] gpio_oe,
  input  wire logic [4:0] gpio_pu_en,
  input  wire logic [4:0] gpio_pd_en,
  input  wire logic [4:0] sw_low,
  output var  logic [4:0] pin
);
  logic [4:0] flt_q = 5'h00;
  // Undriven pins wander so a stale level never reads as valid
  always @(posedge clk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (gpio_oe[i]) pin[i] = gpio_o[i];
      else if (sw_low[i]) pin[i] = 1'b0;
      else if (gpio_pu_en[i]) pin[i] = 1'b1;
      else if (gpio_pd_en[i]) pin[i] = 1'b0;
      else pin[i] = flt_q[i];
    end
  end
endmodule
`default_nettype wire

// *** testbench/gpio_pwm_port_controller_test.sv ***
// Self-checking bench for the pin and pulse-width port controller
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  $display("[ERR] %0t got %h exp %h", $time, g, e); error_cnt++; end end
module gpio_pwm_port_controller_test;
  localparam int STEP = 4;
  logic        clk = 0, rst = 1, sense, irq;
  logic [7:0]  awaddr = 0, araddr = 0, led;
  logic [31:0] wdata = 0, rdata, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [4:0]  pin, output_only_led_line, oe, pu, pd, sw = 0;
  logic        pwr_act = 0, pwr_lvl = 0, rst_act = 0, rst_lvl = 0;
  int          error_cnt = 0, compares = 0, cyc = 0;
  gpp_top #(.PWM_STEP_CYCLES(STEP), .SAMPLE_CYCLES(16)) u_gpp_top (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gpio_i(pin), .gpio_o(output_only_led_line), .gpio_oe(oe), .gpio_pu_en(pu), .gpio_pd_en(pd),
    .led_o(led), .atx_pwr_act(pwr_act), .atx_pwr_lvl(pwr_lvl),
    .atx_rst_act(rst_act), .atx_rst_lvl(rst_lvl), .atx_power_sense(sense), .irq(irq));
  gpp_pin_load u_gpp_pin_load (.clk(clk), .gpio_o(output_only_led_line), .gpio_oe(oe),
    .gpio_pu_en(pu), .gpio_pd_en(pd), .sw_low(sw), .pin(pin));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 1;
    @(posedge clk);
    bready <= 0;
    `CHK(bresp, er)
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er = 2'h0);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 1;
    @(posedge clk);
    rready <= 0;
    rd = rdata;
    `CHK(rresp, er)
  endtask
  task automatic cmd(input logic [7:0] i, l, c, input logic has, input logic [7:0] et);
    wr(`GPP_OFF_CMD, {7'h0, has, c, l, i});
    wr(`GPP_OFF_GO, 32'h1);
    rd_reg(`GPP_OFF_RESP);
    `CHK(rd[7:0], et)
    repeat (4) @(posedge clk);
  endtask
  task automatic query(input logic [7:0] i);
    wr(`GPP_OFF_QUERY, {24'h0, i});
    rd_reg(`GPP_OFF_QRES);
  endtask
  // Expected {oe, o, pu, pd} for a drive mode and a static level
  function automatic logic [3:0] drv(input int m, input logic h);
    case (m)
      0: return h ? 4'b1100 : 4'b0101;
      1, 5: return h ? 4'b1100 : 4'b1000;
      2: return 4'b0000;
      3: return h ? 4'b0010 : 4'b1000;
      4: return h ? 4'b1100 : 4'b0100;
      default: return h ? 4'b0000 : 4'b1000;
    endcase
  endfunction
  task automatic t_reset;
    `CHK({oe, pu, led}, 18'h04000)
    rd_reg(8'h20, 2'h2);
    wr(8'h20, 32'h0, 2'h2);
    rd_reg(`GPP_OFF_IMASK);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_drive;
    for (int m = 0; m < 8; m++) begin
      for (int h = 0; h < 2; h++) begin
        if (m == 6) continue;
        cmd(0, h ? 8'h64 : 8'h00, 8'h08 | m[7:0], 1, 8'h62);
        `CHK({oe[0], output_only_led_line[0], pu[0], pd[0]}, drv(m, h[0]))
      end
    end
    cmd(0, 8'h00, 8'h0e, 1, 8'he2);
    cmd(0, 8'h00, 8'h06, 1, 8'he2);
    cmd(0, 8'h00, 8'h10, 1, 8'he2);
    cmd(0, 8'h65, 8'h09, 1, 8'he2);
    cmd(0, 8'hff, 8'h09, 1, 8'he2);
    cmd(8'h0d, 8'h00, 8'h00, 0, 8'he2);
    `CHK({oe[0], output_only_led_line[0], pu[0], pd[0]}, 4'b0000)
  endtask
  task automatic t_two_byte;
    cmd(0, 8'h64, 8'h09, 1, 8'h62);
    cmd(0, 8'h00, 8'h02, 0, 8'h62);
    `CHK({oe[0], output_only_led_line[0]}, 2'b10)
    query(0);
    `CHK(rd[31:16], 16'h0900)
  endtask
  task automatic t_pwm;
    logic [7:0] lv [5] = '{8'd0, 8'd1, 8'd25, 8'd99, 8'd100};
    logic [15:0] n;
    cmd(5, 8'h64, 8'h0e, 1, 8'h62);
    `CHK(led[0], 1'b1)
    query(5);
    `CHK(rd, 32'h00640005)
    foreach (lv[k]) begin
      cmd(8'h0c, lv[k], 8'h06, 1, 8'h62);
      repeat (100 * STEP) @(posedge clk);
      n = 0;
      repeat (100 * STEP) begin
        @(posedge clk);
        n = n + led[7];
      end
      `CHK(n, lv[k] * STEP)
    end
  endtask
  task automatic t_sample;
    cmd(4, 8'h64, 8'h0b, 1, 8'h62);
    repeat (40) @(posedge clk);
    query(4);
    sw[4] <= 1;
    repeat (40) @(posedge clk);
    query(4);
    `CHK(rd[15:8], 8'h02)
    sw[4] <= 0;
    repeat (40) @(posedge clk);
    query(4);
    `CHK(rd, 32'h0b640504)
    query(4);
    `CHK(rd[15:8], 8'h01)
  endtask
  task automatic t_irq;
    wr(`GPP_OFF_IMASK, 32'h1);
    wr(`GPP_OFF_ISTAT, 32'h7);
    `CHK(irq, 1'b0)
    cmd(5, 8'h00, 8'h00, 0, 8'h62);
    `CHK(irq, 1'b1)
    wr(`GPP_OFF_ISTAT, 32'h1);
    `CHK(irq, 1'b0)
    wr(`GPP_OFF_IMASK, 32'h2);
    cmd(5, 8'h00, 8'h00, 0, 8'h62);
    `CHK(irq, 1'b0)
    rd_reg(`GPP_OFF_ISTAT);
    `CHK(rd[1:0], 2'b01)
    cmd(8'h0d, 8'h00, 8'h00, 0, 8'he2);
    `CHK(irq, 1'b1)
  endtask
  task automatic t_atx;
    pwr_act <= 1;
    rst_act <= 1;
    rst_lvl <= 1;
    repeat (4) @(posedge clk);
    `CHK({oe[3:2], output_only_led_line[3:2]}, 4'b1110)
    cmd(2, 8'h00, 8'h0a, 1, 8'h62);
    `CHK(oe[3:2], 2'b10)
    `CHK(sense, 1'b0)
    cmd(1, 8'h64, 8'h00, 0, 8'h62);
    repeat (40) @(posedge clk);
    `CHK(sense, 1'b1)
  endtask
  task automatic t_store;
    wr(`GPP_OFF_STORE, 32'h1);
    cmd(1, 8'h00, 8'h00, 0, 8'h62);
    wr(`GPP_OFF_STORE, 32'h2);
    query(1);
    `CHK(rd[31:16], 16'h0364)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_reset();
    t_drive();
    t_two_byte();
    t_pwm();
    t_sample();
    t_irq();
    t_atx();
    t_store();
    print_verdict();
  end
endmodule
bind gpp_top gpp_top_chk u_gpp_top_chk (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .gpio_oe(gpio_oe), .gpio_pu_en(gpio_pu_en), .gpio_pd_en(gpio_pd_en), .led_o(led_o),
  .irq(irq));
`default_nettype wire
